// >>> logic/rf_bias_ctrl_out.sv
// Drive logic for the RF front-end bias / switch control output
`timescale 1ns/1ps
`include "rf_bias_consts.svh"

module rf_bias_ctrl_out (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Control word and radio state
    input wire logic [`CTRL_WORD_WIDTH-1:0] i_ctrl_word,
    input wire rf_bias_pkg::radio_state_t i_radio_state,
    // Pin drive (three-state)
    output logic o_rf_bias_ctrl_out,
    output logic o_rf_bias_ctrl_oe
);

    logic bias_out_enable;
    logic bias_polarity_invert;
    logic single_port_select;
    logic level;
    logic drive;
    logic next_level;
    logic next_drive;

    // Control field extraction
    assign bias_out_enable = i_ctrl_word[`BIAS_OUT_ENABLE_BIT];
    assign bias_polarity_invert = i_ctrl_word[`BIAS_POLARITY_INVERT_BIT];
    assign single_port_select = i_ctrl_word[`SINGLE_PORT_SELECT_BIT];

    // Level and drive decision. Transmit and receive pick the level from the
    // mode bit and the invert bit; every other state value, including any
    // code that is not one-hot, falls to the quiet low level. A cleared
    // enable wins last so a floating pin never carries a stale high level.
    always_comb begin
        next_drive = bias_out_enable;
        next_level = 1'b0;
        case (i_radio_state)
            rf_bias_pkg::RADIO_TX: begin
                if (single_port_select) begin
                    next_level = 1'b1;
                end else begin
                    next_level = ~bias_polarity_invert;
                end
            end
            rf_bias_pkg::RADIO_RX: begin
                if (single_port_select) begin
                    next_level = 1'b0;
                end else begin
                    next_level = bias_polarity_invert;
                end
            end
            default: begin
                next_level = 1'b0;
            end
        endcase
        if (!bias_out_enable) begin
            next_level = 1'b0;
        end
    end

    // Output registers. Both pin signals come straight from these flops,
    // so the pad sees no combinational glitch when the inputs change.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            level <= `BIAS_LEVEL_RESET;
            drive <= `BIAS_DRIVE_RESET;
        end else begin
            level <= next_level;
            drive <= next_drive;
        end
    end

    assign o_rf_bias_ctrl_out = level;
    assign o_rf_bias_ctrl_oe = drive;

    // Checks on the registered pin drive. Each one-cycle implication except reset_float_a also
    // asks for reset high at its start edge, since the registers still hold
    // their reset value one edge after reset is released.
    // Disabled output never drives
    float_when_off_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && !bias_out_enable
        |=> !o_rf_bias_ctrl_oe)
        else $error("bias output driven while disabled");

    // Disabled output rests low
    off_level_low_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && !bias_out_enable
        |=> !o_rf_bias_ctrl_out)
        else $error("bias level not low while disabled");

    // High level only while driving
    level_needs_drive_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        o_rf_bias_ctrl_out |-> o_rf_bias_ctrl_oe)
        else $error("bias level high while floating");

    // Enabled output drives next cycle
    drive_when_on_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && bias_out_enable
        |=> o_rf_bias_ctrl_oe)
        else $error("bias output not driven while enabled");

    // Drive enable follows the enable bit by one clock
    oe_tracks_en_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst |=> o_rf_bias_ctrl_oe == $past(bias_out_enable))
        else $error("drive enable does not follow the enable bit");

    // Steady inputs give steady outputs
    outputs_stand_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && $past(i_nrst) && $stable(i_ctrl_word)
        && $stable(i_radio_state)
        |=> $stable(o_rf_bias_ctrl_out) && $stable(o_rf_bias_ctrl_oe))
        else $error("bias outputs moved with steady inputs");

    // Single-port transmit high
    single_tx_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && bias_out_enable && single_port_select
        && i_radio_state == rf_bias_pkg::RADIO_TX
        |=> o_rf_bias_ctrl_out)
        else $error("single-port transmit level wrong");

    // Single-port receive low
    single_rx_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && bias_out_enable && single_port_select
        && i_radio_state == rf_bias_pkg::RADIO_RX
        |=> !o_rf_bias_ctrl_out)
        else $error("single-port receive level wrong");

    // Single-port level ignores a set invert bit
    single_inv_free_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && bias_out_enable && single_port_select
        && bias_polarity_invert
        && (i_radio_state == rf_bias_pkg::RADIO_TX
        || i_radio_state == rf_bias_pkg::RADIO_RX)
        |=> o_rf_bias_ctrl_out
        == $past(i_radio_state == rf_bias_pkg::RADIO_TX))
        else $error("single-port level swayed by invert");

    // Dual-port transmit is the complement of invert
    dual_tx_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && bias_out_enable && !single_port_select
        && i_radio_state == rf_bias_pkg::RADIO_TX
        |=> o_rf_bias_ctrl_out == !$past(bias_polarity_invert))
        else $error("dual-port transmit level wrong");

    // Dual-port receive follows invert
    dual_rx_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && bias_out_enable && !single_port_select
        && i_radio_state == rf_bias_pkg::RADIO_RX
        |=> o_rf_bias_ctrl_out == $past(bias_polarity_invert))
        else $error("dual-port receive level wrong");

    // Inverted dual-port transmit is low
    dual_tx_inv_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && bias_out_enable && !single_port_select
        && bias_polarity_invert
        && i_radio_state == rf_bias_pkg::RADIO_TX
        |=> !o_rf_bias_ctrl_out)
        else $error("inverted dual-port transmit not low");

    // Plain dual-port receive is low
    dual_rx_plain_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && bias_out_enable && !single_port_select
        && !bias_polarity_invert
        && i_radio_state == rf_bias_pkg::RADIO_RX
        |=> !o_rf_bias_ctrl_out)
        else $error("plain dual-port receive not low");

    // Quiet states drive low
    quiet_low_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && bias_out_enable && i_radio_state != rf_bias_pkg::RADIO_TX
        && i_radio_state != rf_bias_pkg::RADIO_RX
        |=> o_rf_bias_ctrl_oe && !o_rf_bias_ctrl_out)
        else $error("quiet state not driven low");

    // Idle drives low
    idle_low_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && bias_out_enable
        && i_radio_state == rf_bias_pkg::RADIO_IDLE
        |=> o_rf_bias_ctrl_oe && !o_rf_bias_ctrl_out)
        else $error("idle state not driven low");

    // Doze drives low
    doze_low_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && bias_out_enable
        && i_radio_state == rf_bias_pkg::RADIO_DOZE
        |=> o_rf_bias_ctrl_oe && !o_rf_bias_ctrl_out)
        else $error("doze state not driven low");

    // Hibernate drives low rather than floating
    hibernate_low_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_nrst && bias_out_enable
        && i_radio_state == rf_bias_pkg::RADIO_HIBERNATE
        |=> o_rf_bias_ctrl_oe && !o_rf_bias_ctrl_out)
        else $error("hibernate state not driven low");

    // Reset values float output
    reset_float_a: assert property (
        @(posedge i_clk)
        !i_nrst |=> !o_rf_bias_ctrl_oe && !o_rf_bias_ctrl_out)
        else $error("output not released in reset");

endmodule : rf_bias_ctrl_out

// >>> logic/rf_bias_consts.svh
// Bit positions and reset values for the bias output control word
`ifndef RF_BIAS_CONSTS_SVH
`define RF_BIAS_CONSTS_SVH
`define CTRL_WORD_WIDTH 16
`define BIAS_OUT_ENABLE_BIT 14
`define BIAS_POLARITY_INVERT_BIT 13
`define SINGLE_PORT_SELECT_BIT 12
`define CTRL_WORD_RESET 16'h0000
`define BIAS_LEVEL_RESET 1'b0
`define BIAS_DRIVE_RESET 1'b0
`endif

// >>> logic/rf_bias_pkg.sv
// Types shared by the bias output logic
package rf_bias_pkg;
    // Radio operating state, one-hot
    typedef enum logic [4:0] {
        RADIO_IDLE = 5'h01,
        RADIO_RX = 5'h02,
        RADIO_TX = 5'h04,
        RADIO_DOZE = 5'h08,
        RADIO_HIBERNATE = 5'h10
    } radio_state_t;
endpackage : rf_bias_pkg

// >>> sim/rf_front_end_model.sv
// Far-side switch model: level seen on the bias pin
`timescale 1ns/1ps
module rf_front_end_model (
    // Pin drive from the device
    input wire logic i_clk,
    input wire logic i_drv,
    input wire logic i_oe,
    // Level seen by the switch
    output logic o_level
);
    logic last = 1'b0;
    // Undriven pin has no pull, so it wanders off the last level
    always_ff @(posedge i_clk) begin
        last <= o_level;
    end
    assign o_level = i_oe ? i_drv : ~last;
endmodule : rf_front_end_model

// >>> sim/testbench.sv
// Self-checking bench for the bias control output
`timescale 1ns/1ps
module testbench;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [15:0] ctrl = 16'h0000;
    rf_bias_pkg::radio_state_t st = rf_bias_pkg::RADIO_IDLE;
    logic out, oe, lvl;
    int errors = 0;
    int comparisons = 0;
    // Clock at 200 MHz
    always #2.5 i_clk = ~i_clk;
    rf_bias_ctrl_out dut_u (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_ctrl_word(ctrl), .i_radio_state(st),
        .o_rf_bias_ctrl_out(out), .o_rf_bias_ctrl_oe(oe));
    rf_front_end_model far_u (.i_clk(i_clk), .i_drv(out), .i_oe(oe),
        .o_level(lvl));
    // Compare one bit
    task automatic chk(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask : chk
    // Drive inputs, check outputs one edge later
    task automatic go(input logic [15:0] c, input logic [4:0] s,
        input logic eo, input logic ev);
        @(posedge i_clk);
        ctrl <= c;
        st <= rf_bias_pkg::radio_state_t'(s);
        @(posedge i_clk);
        #1;
        chk("oe", eo, oe);
        chk("out", ev, out);
        if (eo) begin
            chk("pin", ev, lvl);
        end
    endtask : go
    // Disabled output floats in every state
    task automatic t_off();
        for (int i = 0; i < 5; i++) begin
            go(16'hBFFF, 5'h01 << i, 1'b0, 1'b0);
        end
    endtask : t_off
    // Single port ignores invert; dual port honours it
    task automatic t_modes();
        go(16'h5000, 5'h04, 1'b1, 1'b1);
        go(16'h7000, 5'h02, 1'b1, 1'b0);
        go(16'h7000, 5'h04, 1'b1, 1'b1);
        go(16'h4000, 5'h02, 1'b1, 1'b0);
        go(16'h4000, 5'h04, 1'b1, 1'b1);
        go(16'h6000, 5'h04, 1'b1, 1'b0);
        go(16'h6000, 5'h02, 1'b1, 1'b1);
    endtask : t_modes
    // Quiet states drive low, then mid-run reset floats the pin
    task automatic t_quiet();
        go(16'h6000, 5'h01, 1'b1, 1'b0);
        go(16'h7000, 5'h08, 1'b1, 1'b0);
        go(16'h6000, 5'h10, 1'b1, 1'b0);
        go(16'h6000, 5'h02, 1'b1, 1'b1);
        @(posedge i_clk);
        i_nrst <= 1'b0;
        #1;
        chk("oe", 1'b0, oe);
        chk("out", 1'b0, out);
        @(posedge i_clk);
        i_nrst <= 1'b1;
        go(16'h6000, 5'h04, 1'b1, 1'b0);
    endtask : t_quiet
    // Print counts and verdict
    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    // Main sequence
    initial begin
        repeat (2) @(posedge i_clk);
        #1;
        chk("oe", 1'b0, oe);
        chk("out", 1'b0, out);
        @(posedge i_clk);
        i_nrst <= 1'b1;
        t_off();
        t_modes();
        t_quiet();
        conclude();
    end
    // Watchdog
    initial begin
        #2000;
        errors++;
        conclude();
    end
endmodule : testbench
